// ### rtl/smi_pkg.sv
package smi_pkg;
  // operand width of one datapath (documented slice width cascaded)
  localparam int unsigned WIDTH = 8;
  localparam int unsigned CNT_W = 4;
  // reset values and last iteration count
  localparam logic [WIDTH-1:0] ACC_RST = 8'h00;
  localparam logic [WIDTH-1:0] EXT_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [CNT_W-1:0] ITER_LAST = 4'h7;
  // register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_MCAND = 12'h004;
  localparam logic [11:0] OFS_ACC = 12'h008;
  localparam logic [11:0] OFS_EXT = 12'h00C;
  localparam logic [11:0] OFS_STAT = 12'h010;
  // control field positions
  localparam int unsigned CTRL_CLR_BIT = 0;
  localparam int unsigned CTRL_LOAD_BIT = 1;
  localparam int unsigned CTRL_ITER_BIT = 2;
  localparam int unsigned CTRL_ASH_BIT = 3;
  // status field positions
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_HI_BIT = 2;
  localparam int unsigned STAT_LO_BIT = 3;
  localparam int unsigned STAT_ERR_BIT = 4;

  // decoded multiplier status for one iteration
  typedef struct packed {
    logic sign_flag;
    logic cur_lsb;
    logic lsb_flag;
  } smi_dec_s;

  // four microinstructions chosen per step
  typedef enum logic [1:0] {
    SMI_SHIFT = 2'b00,
    SMI_ADD   = 2'b01,
    SMI_SUB   = 2'b10,
    SMI_FIX   = 2'b11
  } smi_op_e;
endpackage : smi_pkg

// ### rtl/smi_step.sv
`timescale 1ns/10ps
// one iteration: add/sub multiplicand into acc, arithmetic shift right
module smi_step
  import smi_pkg::*;
(
  input  wire logic [WIDTH-1:0] acc_i,
  input  wire logic [WIDTH-1:0] ext_i,
  input  wire logic [WIDTH-1:0] mcand_i,
  input  wire smi_op_e          op_i,
  output logic      [WIDTH-1:0] acc_o,
  output logic      [WIDTH-1:0] ext_o
);
  logic [WIDTH:0] sum;

  // sign extended add or subtract, then shift both registers
  always_comb begin
    unique case (op_i)
      SMI_ADD: sum = {acc_i[WIDTH-1], acc_i} + {mcand_i[WIDTH-1], mcand_i};
      SMI_SUB,
      SMI_FIX: sum = {acc_i[WIDTH-1], acc_i} - {mcand_i[WIDTH-1], mcand_i};
      SMI_SHIFT: sum = {acc_i[WIDTH-1], acc_i};
    endcase
    acc_o = sum[WIDTH:1];
    ext_o = {sum[0], ext_i[WIDTH-1:1]};
  end
endmodule : smi_step

// ### rtl/smi_core.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
// Operation
// - signed N-bit multiply in N iterate writes
// - high half in accumulator, low in extension
// - negative product kept as two's complement
// - iterate decodes sign flag, lsb, lsb flag
// - top slice drives two select outputs
module smi_core
  import smi_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             MICROCONTROL_OUT_HI_O,
  output logic             MICROCONTROL_OUT_HI_OE_O,
  output logic             MICROCONTROL_OUT_LO_O,
  output logic             MICROCONTROL_OUT_LO_OE_O,
  output logic             EQUALITY_STATUS_O,
  output logic             ARITH_GREATER_STATUS_O,
  output logic             LOGIC_GREATER_STATUS_O,
  output logic             OVERFLOW_STATUS_O
);
  logic [WIDTH-1:0] acc_ff, nxt_acc;
  logic [WIDTH-1:0] ext_ff, nxt_ext;
  logic [WIDTH-1:0] mcand_ff, nxt_mcand;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic             busy_ff, nxt_busy;
  logic             done_ff, nxt_done;
  logic             err_ff, nxt_err;
  logic             lsbf_ff, nxt_lsbf;
  logic             sign_ff, nxt_sign;
  logic [31:0]      rdata_ff, nxt_rdata;
  logic             loaded_ff, nxt_loaded;
  logic             wr_en;
  logic             rd_en;
  logic             ash_req;
  logic             iter_req;
  logic             last;
  smi_dec_s         dec;
  smi_op_e          op;
  logic [WIDTH-1:0] step_acc;
  logic [WIDTH-1:0] step_ext;

  // apb decode, zero wait state
  // read data captured in setup cycle, stands through access
  assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en     = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I &
                     (PADDR_I[1:0] != 2'b00 || PADDR_I > OFS_STAT);
  assign PRDATA_O  = rdata_ff;
  assign iter_req  = wr_en && PADDR_I == OFS_CTRL && PWDATA_I[CTRL_ITER_BIT];
  assign ash_req   = wr_en && PADDR_I == OFS_CTRL && PWDATA_I[CTRL_ASH_BIT];
  assign last      = cnt_ff == ITER_LAST;

  // decode of multiplier status on each iterate
  always_comb begin
    dec.sign_flag = sign_ff;
    dec.cur_lsb   = ext_ff[0];
    dec.lsb_flag  = lsbf_ff;
    // booth pair; sign step uses subtract on last bit
    unique case ({dec.cur_lsb, dec.lsb_flag})
      2'b10:   op = last ? SMI_FIX : SMI_SUB;
      2'b01:   op = SMI_ADD;
      default: op = SMI_SHIFT;
    endcase
  end

  smi_step u_step (
    .acc_i   (acc_ff),
    .ext_i   (ext_ff),
    .mcand_i (mcand_ff),
    .op_i    (op),
    .acc_o   (step_acc),
    .ext_o   (step_ext)
  );

  // datapath and sequence next values
  always_comb begin
    nxt_acc    = acc_ff;
    nxt_ext    = ext_ff;
    nxt_mcand  = mcand_ff;
    nxt_cnt    = cnt_ff;
    nxt_busy   = busy_ff;
    nxt_done   = done_ff;
    nxt_err    = err_ff;
    nxt_lsbf   = lsbf_ff;
    nxt_sign   = sign_ff;
    nxt_loaded = loaded_ff;
    if (wr_en && PADDR_I == OFS_MCAND) begin
      nxt_mcand = PWDATA_I[WIDTH-1:0];
    end
    if (wr_en && PADDR_I == OFS_ACC) begin
      nxt_acc = PWDATA_I[WIDTH-1:0];
    end
    if (wr_en && PADDR_I == OFS_CTRL && PWDATA_I[CTRL_CLR_BIT]) begin
      nxt_acc = ACC_RST;
    end
    if (wr_en && PADDR_I == OFS_EXT) begin
      nxt_ext    = PWDATA_I[WIDTH-1:0];
      nxt_lsbf   = 1'b0;
      nxt_sign   = PWDATA_I[WIDTH-1];
      nxt_loaded = 1'b1;
      nxt_done   = 1'b0;
      nxt_cnt    = CNT_RST;
    end
    if (ash_req) begin
      // shift before first iteration corrupts setup; flagged
      nxt_ext = {acc_ff[0], ext_ff[WIDTH-1:1]};
      nxt_acc = {acc_ff[WIDTH-1], acc_ff[WIDTH-1:1]};
      if (loaded_ff && !busy_ff) begin
        nxt_err = 1'b1;
      end
    end
    if (iter_req) begin
      nxt_acc  = step_acc;
      nxt_ext  = step_ext;
      nxt_lsbf = ext_ff[0];
      nxt_cnt  = last ? CNT_RST : cnt_ff + 4'h1;
      nxt_busy = !last;
      nxt_done = last;
      nxt_loaded = 1'b0;
      // a shift in the same write sets the flag; set wins
      if (!busy_ff && !ash_req) begin
        nxt_err = 1'b0;
      end
    end
  end

  // read mux, held between reads so data stands at the access edge
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_en) begin
      nxt_rdata = 32'h0000_0000;
      unique case (PADDR_I)
        OFS_MCAND: nxt_rdata[WIDTH-1:0] = mcand_ff;
        OFS_ACC:   nxt_rdata[WIDTH-1:0] = acc_ff;
        OFS_EXT:   nxt_rdata[WIDTH-1:0] = ext_ff;
        OFS_STAT: begin
          nxt_rdata[STAT_BUSY_BIT] = busy_ff;
          nxt_rdata[STAT_DONE_BIT] = done_ff;
          nxt_rdata[STAT_HI_BIT]   = MICROCONTROL_OUT_HI_O;
          nxt_rdata[STAT_LO_BIT]   = MICROCONTROL_OUT_LO_O;
          nxt_rdata[STAT_ERR_BIT]  = err_ff;
        end
        default:   nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register all state except read data
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      acc_ff    <= ACC_RST;
      ext_ff    <= EXT_RST;
      mcand_ff  <= ACC_RST;
      cnt_ff    <= CNT_RST;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      err_ff    <= 1'b0;
      lsbf_ff   <= 1'b0;
      sign_ff   <= 1'b0;
      loaded_ff <= 1'b0;
    end else begin
      acc_ff    <= nxt_acc;
      ext_ff    <= nxt_ext;
      mcand_ff  <= nxt_mcand;
      cnt_ff    <= nxt_cnt;
      busy_ff   <= nxt_busy;
      done_ff   <= nxt_done;
      err_ff    <= nxt_err;
      lsbf_ff   <= nxt_lsbf;
      sign_ff   <= nxt_sign;
      loaded_ff <= nxt_loaded;
    end
  end

  // register read data
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // open-collector select pins: drive low only, enable when low while busy or loaded
  assign MICROCONTROL_OUT_HI_O    = op[1];
  assign MICROCONTROL_OUT_LO_O    = op[0];
  assign MICROCONTROL_OUT_HI_OE_O = (busy_ff | loaded_ff) & ~op[1];
  assign MICROCONTROL_OUT_LO_OE_O = (busy_ff | loaded_ff) & ~op[0];

  // equality status flags accumulator zero; the other status outputs are tied low
  assign EQUALITY_STATUS_O      = acc_ff == ACC_RST;
  assign ARITH_GREATER_STATUS_O = 1'b0;
  assign LOGIC_GREATER_STATUS_O = 1'b0;
  assign OVERFLOW_STATUS_O      = 1'b0;
endmodule : smi_core

// ### verification/smi_core_properties.sv
`timescale 1ns/10ps
module smi_core_properties
  import smi_pkg::*;
(
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        MICROCONTROL_OUT_HI_O,
  input wire logic        MICROCONTROL_OUT_HI_OE_O,
  input wire logic        MICROCONTROL_OUT_LO_O,
  input wire logic        MICROCONTROL_OUT_LO_OE_O,
  input wire logic        EQUALITY_STATUS_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // access phase and status read qualifiers
  wire logic acc = PSEL_I && PENABLE_I;
  wire logic st_rd = acc && !PWRITE_I && PADDR_I == OFS_STAT;
  chk_ready_access: assert property (acc |-> PREADY_O)
    else $error("ready low in access");
  chk_hi_pulls_low: assert property (MICROCONTROL_OUT_HI_OE_O |-> !MICROCONTROL_OUT_HI_O)
    else $error("high select driven while bit set");
  chk_lo_pulls_low: assert property (MICROCONTROL_OUT_LO_OE_O |-> !MICROCONTROL_OUT_LO_O)
    else $error("low select driven while bit set");
  chk_acc_zero_flag: assert property (acc && PWRITE_I && PADDR_I == OFS_ACC
    |=> EQUALITY_STATUS_O == ($past(PWDATA_I[7:0]) == 8'h00)) else $error("zero flag wrong");
  chk_busy_done_excl: assert property (st_rd
    |-> !(PRDATA_O[STAT_BUSY_BIT] && PRDATA_O[STAT_DONE_BIT])) else $error("busy with done");
  chk_sel_mirrors: assert property (st_rd
    |-> PRDATA_O[STAT_HI_BIT] == $past(MICROCONTROL_OUT_HI_O)) else $error("select not shown");
endmodule : smi_core_properties
bind smi_core smi_core_properties chk_u (.*);

// ### verification/smi_ctrl_model.sv
`timescale 1ns/10ps
module smi_ctrl_model
  import smi_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o
);
  bit timed_out = 1'b0;
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  // one bus transfer; response taken at the access edge, then one idle cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 8);
    if (pready_i !== 1'b1) timed_out = 1'b1;
    e = pslverr_i;
    q = prdata_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  // full multiply sequence as the controller runs it
  task automatic mul(input logic [7:0] a, b, output logic [15:0] p);
    logic [31:0] q;
    logic [31:0] r;
    logic        e;
    xfer(1'b1, OFS_EXT, {24'h00_0000, b}, q, e);
    xfer(1'b1, OFS_CTRL, 32'h0000_0001, q, e);
    xfer(1'b1, OFS_MCAND, {24'h00_0000, a}, q, e);
    repeat (WIDTH) xfer(1'b1, OFS_CTRL, 32'h0000_0004, q, e);
    xfer(1'b0, OFS_ACC, '0, q, e);
    xfer(1'b0, OFS_EXT, '0, r, e);
    p = {q[7:0], r[7:0]};
  endtask : mul
endmodule : smi_ctrl_model

// ### verification/signed_multiply_iteration_bench.sv
`timescale 1ns/10ps
module signed_multiply_iteration_bench
  import smi_pkg::*;
;
  logic CLOCK_I = 1'b0;
  logic RST_N_I = 1'b0;
  wire logic PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
  wire logic MICROCONTROL_OUT_HI_O, MICROCONTROL_OUT_HI_OE_O, MICROCONTROL_OUT_LO_O;
  wire logic MICROCONTROL_OUT_LO_OE_O, EQUALITY_STATUS_O, ARITH_GREATER_STATUS_O;
  wire logic LOGIC_GREATER_STATUS_O, OVERFLOW_STATUS_O;
  wire logic [11:0] PADDR_I;
  wire logic [31:0] PWDATA_I, PRDATA_O;
  int errors = 0;
  int num_checks = 0;
  always #12.5 CLOCK_I = ~CLOCK_I;
  smi_core dut_u (.*);
  smi_ctrl_model ctl_u (.clk_i(CLOCK_I), .prdata_i(PRDATA_O), .pready_i(PREADY_O),
    .pslverr_i(PSLVERR_O), .psel_o(PSEL_I), .penable_o(PENABLE_I), .pwrite_o(PWRITE_I),
    .paddr_o(PADDR_I), .pwdata_o(PWDATA_I));
  // signed product, operands sign extended to full length
  function automatic logic [15:0] prod(input logic [7:0] a, b);
    return {{8{a[7]}}, a} * {{8{b[7]}}, b};
  endfunction : prod
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp || ctl_u.timed_out) begin
      errors++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
    if (ctl_u.timed_out) end_of_test();
  endtask : check
  // corner operands, then random ones
  initial begin
    static logic [15:0] c [5] = '{16'h8080, 16'h807F, 16'hFFFF, 16'h7F81, 16'h009C};
    logic [15:0] p;
    logic [31:0] q;
    logic [7:0]  a, b;
    logic        e;
    void'($urandom(32'h17d4));
    repeat (2) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    for (int i = 0; i < 25; i++) begin
      {a, b} = i < 5 ? c[i] : 16'($urandom);
      ctl_u.mul(a, b, p);
      check({16'h0000, p}, {16'h0000, prod(a, b)});
    end
    ctl_u.xfer(1'b0, OFS_STAT, '0, q, e);
    check({30'h0, q[STAT_DONE_BIT], q[STAT_BUSY_BIT]}, 32'h0000_0002);
    foreach (c[i]) begin
      a = i[0] ? 8'($urandom) : 8'h00;
      ctl_u.xfer(1'b1, OFS_ACC, {24'h00_0000, a}, q, e);
      ctl_u.xfer(1'b0, OFS_ACC, '0, q, e);
      check(q, {24'h00_0000, a});
    end
    ctl_u.xfer(1'b1, OFS_EXT, 32'h0000_0035, q, e);
    ctl_u.xfer(1'b0, OFS_STAT, '0, q, e);
    check({30'h0, q[STAT_HI_BIT], q[STAT_LO_BIT]}, {30'h0, SMI_SUB});
    ctl_u.xfer(1'b1, OFS_CTRL, 32'h0000_0008, q, e);
    ctl_u.xfer(1'b0, OFS_STAT, '0, q, e);
    check({31'h0, q[STAT_ERR_BIT]}, 32'h0000_0001);
    ctl_u.xfer(1'b0, 12'h014, '0, q, e);
    check({31'h0, e}, 32'h0000_0001);
    end_of_test();
  end
endmodule : signed_multiply_iteration_bench
